/* src/fcs_map.svh */
// Register offsets, field positions, reset values and timing figures.
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// ==========================================================
// Register offsets
`define FCS_ADDR_CTRL 8'h00
`define FCS_ADDR_MRDATA 8'h04
`define FCS_ADDR_MR0 8'h08
`define FCS_ADDR_MR2 8'h0C
`define FCS_ADDR_STATUS 8'h10
// ==========================================================
// Field positions
`define FCS_CTRL_GO 0
`define FCS_CTRL_OP_LSB 1
`define FCS_CTRL_OP_MSB 2
`define FCS_CTRL_ODT 3
`define FCS_CTRL_DIV_LSB 8
`define FCS_CTRL_DIV_MSB 15
`define FCS_MRSEL_LSB 16
`define FCS_MRSEL_MSB 17
`define FCS_DLL_RST_BIT 8
`define FCS_RTT_BIT_A 2
`define FCS_RTT_BIT_B 6
`define FCS_RTT_BIT_C 9
// ==========================================================
// Reset values and limits
`define FCS_DIV_RESET 8'h02
`define FCS_DIV_MIN 8'h01
`define FCS_DIV_MAX 8'h10
`define FCS_MR_RESET 16'h0000
`define FCS_MR1_SEL 2'h1
`define FCS_MR0_SEL 2'h0
`define FCS_MR2_SEL 2'h2
`define FCS_RESP_OKAY 2'h0
`define FCS_RESP_SLVERR 2'h2
// ==========================================================
// Timing
`define FCS_CORE_NS 40
`define FCS_T_CKSRE_NS 10
`define FCS_T_CKSRX_NS 10
`define FCS_T_XP_NS 6
`define FCS_T_XS_NS 170
`define FCS_T_MRD_NCK 10'h004
`define FCS_T_DLLK_NCK 10'h200
`define FCS_T_CKSRE_NCK 10'h005
`define FCS_T_EDGE_GUARD 10'h001
`endif

/* src/fcs_pkg.sv */
// Shared types of the clock frequency change sequencer.
package fcs_pkg;
  typedef enum logic [1:0] {CMD_NOP, CMD_MRS, CMD_SRE} fcs_cmd_t;
  typedef enum logic [1:0] {OP_NONE, OP_SR, OP_PD, OP_MRS} fcs_op_t;
  typedef enum logic [2:0] {C_IDLE, C_WAIT_SRE, C_CHANGE, C_WAIT_SRX,
    C_WAIT_XP, C_WAIT_MR0, C_WAIT_DLLK, C_WAIT_MRD} fcs_cst_t;
  typedef enum logic [1:0] {D_IDLE, D_SREF, D_PDN, D_RELOCK} fcs_dst_t;
endpackage : fcs_pkg

/* src/fcs_link_if.sv */
// Command and clock link between controller and memory.
`timescale 1ns/1ps
interface fcs_link_if;
  logic ck;
  logic cke;
  logic odt;
  fcs_pkg::fcs_cmd_t cmd;
  logic [1:0] mr_sel;
  logic [15:0] addr;
  modport ctrl (output ck, output cke, output odt, output cmd,
    output mr_sel, output addr);
  modport mem (input ck, input cke, input odt, input cmd,
    input mr_sel, input addr);
endinterface : fcs_link_if

/* src/fcs_nck_cnt.sv */
// Down counter of memory clock edges.
`timescale 1ns/1ps
module fcs_nck_cnt #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  // Status
  output logic done
);
  logic [W-1:0] cnt_ff;
  assign done = (cnt_ff == '0);
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_ff <= '0;
    else if (load)
      cnt_ff <= load_val;
    else if (tick && !done)
      cnt_ff <= cnt_ff - 1'b1;
  end
endmodule : fcs_nck_cnt

/* src/fcs_mem.sv */
// Memory end: self-refresh, power-down and DLL relock behaviour.
`timescale 1ns/1ps
`include "fcs_map.svh"
module fcs_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link
  fcs_link_if.mem link,
  // Status
  output logic dll_locked,
  output logic clk_ignored,
  output logic rtt_on,
  output logic [1:0] mem_state
);
  fcs_pkg::fcs_dst_t state_ff;
  logic ck_d_ff;
  logic dll_ff;
  logic ign_ff;
  logic rtt_ff;
  logic rtt_en_ff;
  logic cnt_ld;
  logic [9:0] cnt_val;
  logic cnt_done;
  // ==========================================================
  // Edge detection and decode
  // Clock edges ignored in self-refresh once tCKSRE passed.
  wire ck_rise = link.ck && !ck_d_ff && !ign_ff;
  wire is_mrs = ck_rise && (link.cmd == fcs_pkg::CMD_MRS);
  wire dll_rst = is_mrs && (link.mr_sel == `FCS_MR0_SEL)
    && link.addr[`FCS_DLL_RST_BIT];
  wire mr1_wr = is_mrs && (link.mr_sel == `FCS_MR1_SEL);
  wire mr1_rtt = link.addr[`FCS_RTT_BIT_A] | link.addr[`FCS_RTT_BIT_B]
    | link.addr[`FCS_RTT_BIT_C];
  wire in_idle = (state_ff == fcs_pkg::D_IDLE);
  wire go_low = in_idle && ck_rise && !link.cke;
  assign cnt_ld = dll_rst || go_low;
  assign cnt_val = dll_rst ? `FCS_T_DLLK_NCK : `FCS_T_CKSRE_NCK;
  assign dll_locked = dll_ff;
  assign clk_ignored = ign_ff;
  assign rtt_on = rtt_ff;
  assign mem_state = state_ff;
  fcs_nck_cnt #(.W(10)) u_cnt (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(cnt_ld),
    .load_val(cnt_val),
    .tick(ck_rise),
    .done(cnt_done)
  );
  // ==========================================================
  // State
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= fcs_pkg::D_IDLE;
    else if (dll_rst)
      state_ff <= fcs_pkg::D_RELOCK;
    else
      case (state_ff)
        fcs_pkg::D_IDLE:
          if (go_low)
            state_ff <= (link.cmd == fcs_pkg::CMD_SRE) ?
              fcs_pkg::D_SREF : fcs_pkg::D_PDN;
        fcs_pkg::D_SREF, fcs_pkg::D_PDN:
          if (ck_rise && link.cke)
            state_ff <= fcs_pkg::D_IDLE;
        fcs_pkg::D_RELOCK:
          if (cnt_done)
            state_ff <= fcs_pkg::D_IDLE;
        default:
          state_ff <= fcs_pkg::D_IDLE;
      endcase
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ck_d_ff <= 1'b0;
    else
      ck_d_ff <= link.ck;
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ign_ff <= 1'b0;
    else if (state_ff == fcs_pkg::D_SREF && cnt_done && !link.cke)
      ign_ff <= 1'b1;
    else if (link.cke)
      ign_ff <= 1'b0;
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      dll_ff <= 1'b1;
    else if (dll_rst)
      dll_ff <= 1'b0;
    else if (state_ff == fcs_pkg::D_RELOCK && cnt_done)
      dll_ff <= 1'b1;
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rtt_en_ff <= 1'b0;
    else if (mr1_wr)
      rtt_en_ff <= mr1_rtt;
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rtt_ff <= 1'b0;
    else
      rtt_ff <= link.odt && rtt_en_ff && link.cke
        && (in_idle || state_ff == fcs_pkg::D_RELOCK);
  end
endmodule : fcs_mem

/* src/fcs_ctrl.sv */
// Controller end: AXI4-Lite registers and frequency change sequence.
`timescale 1ns/1ps
`include "fcs_map.svh"
module fcs_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link
  fcs_link_if.ctrl link
);
  logic awr_ff, wr_ff, bv_ff, arr_ff, rv_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff;
  logic [7:0] awaddr_ff;
  logic go_ff, err_ff, done_ff, odt_idle_ff, rtt_ff;
  fcs_pkg::fcs_op_t op_ff;
  logic [7:0] new_div_ff, div_ff, phase_ff;
  logic [17:0] mrdata_ff;
  logic [15:0] mr0_ff, mr2_ff;
  fcs_pkg::fcs_cst_t state_ff, nxt_state;
  logic ck_ff, cke_ff, odt_ff, nxt_cke, nxt_odt;
  fcs_pkg::fcs_cmd_t cmd_ff, nxt_cmd;
  logic [1:0] sel_ff, nxt_sel;
  logic [15:0] addr_ff, nxt_addr;
  logic take, ld, div_ld, dllk_ld, cnt_done, dllk_done;
  logic [9:0] ld_val;
  // ==========================================================
  // Register bus decode
  assign s_axi_awready = awr_ff;
  assign s_axi_wready = wr_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  wire aw_hs = s_axi_awvalid && awr_ff;
  wire w_hs = s_axi_wvalid && wr_ff;
  wire aw_have = aw_hs || !awr_ff;
  wire w_have = w_hs || !wr_ff;
  wire wr_do = aw_have && w_have && !bv_ff;
  wire [7:0] wa = aw_hs ? s_axi_awaddr : awaddr_ff;
  wire [31:0] wd = w_hs ? s_axi_wdata : wdata_ff;
  wire busy = go_ff || (state_ff != fcs_pkg::C_IDLE);
  wire wr_ctrl = wr_do && (wa == `FCS_ADDR_CTRL);
  wire wr_mrd = wr_do && (wa == `FCS_ADDR_MRDATA);
  wire wr_mr0 = wr_do && (wa == `FCS_ADDR_MR0);
  wire wr_mr2 = wr_do && (wa == `FCS_ADDR_MR2);
  wire wr_ok = wr_ctrl || wr_mrd || wr_mr0 || wr_mr2;
  wire [7:0] wdiv = wd[`FCS_CTRL_DIV_MSB:`FCS_CTRL_DIV_LSB];
  wire [1:0] wop = wd[`FCS_CTRL_OP_MSB:`FCS_CTRL_OP_LSB];
  wire freq_op = (wop == fcs_pkg::OP_SR) || (wop == fcs_pkg::OP_PD);
  wire div_bad = freq_op && (wdiv < `FCS_DIV_MIN || wdiv > `FCS_DIV_MAX);
  wire go_set = wr_ctrl && wd[`FCS_CTRL_GO] && !busy && !div_bad
    && s_axi_wstrb[0];
  wire err_set = wr_ctrl && wd[`FCS_CTRL_GO] && (busy || div_bad);
  wire ar_hs = s_axi_arvalid && arr_ff;
  wire rd_ctrl = (s_axi_araddr == `FCS_ADDR_CTRL);
  wire rd_mrd = (s_axi_araddr == `FCS_ADDR_MRDATA);
  wire rd_mr0 = (s_axi_araddr == `FCS_ADDR_MR0);
  wire rd_mr2 = (s_axi_araddr == `FCS_ADDR_MR2);
  wire rd_stat = (s_axi_araddr == `FCS_ADDR_STATUS);
  wire rd_ok = rd_ctrl || rd_mrd || rd_mr0 || rd_mr2 || rd_stat;
  wire [31:0] rd_val =
    rd_ctrl ? {16'h0000, new_div_ff, 4'h0, odt_idle_ff, op_ff, 1'b0} :
    rd_mrd ? {14'h0000, mrdata_ff} :
    rd_mr0 ? {16'h0000, mr0_ff} :
    rd_mr2 ? {16'h0000, mr2_ff} :
    rd_stat ? {8'h00, div_ff, 8'h00, 1'b0, state_ff, rtt_ff, done_ff,
      err_ff, busy} : 32'h0000_0000;
  // ==========================================================
  // Register bus handshakes
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awr_ff <= 1'b1;
      wr_ff <= 1'b1;
      bv_ff <= 1'b0;
      bresp_ff <= `FCS_RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
    end
    else
    begin
      if (aw_hs)
        awaddr_ff <= s_axi_awaddr;
      if (w_hs)
        wdata_ff <= s_axi_wdata;
      awr_ff <= wr_do ? 1'b0 : (awr_ff && !aw_hs) || (bv_ff && s_axi_bready);
      wr_ff <= wr_do ? 1'b0 : (wr_ff && !w_hs) || (bv_ff && s_axi_bready);
      if (wr_do)
      begin
        bv_ff <= 1'b1;
        bresp_ff <= wr_ok ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bv_ff <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      arr_ff <= 1'b1;
      rv_ff <= 1'b0;
      rresp_ff <= `FCS_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end
    else if (ar_hs)
    begin
      arr_ff <= 1'b0;
      rv_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_ok ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
    end
    else if (rv_ff && s_axi_rready)
    begin
      arr_ff <= 1'b1;
      rv_ff <= 1'b0;
    end
  end
  // ==========================================================
  // Software registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_ff <= fcs_pkg::OP_NONE;
      new_div_ff <= `FCS_DIV_RESET;
      odt_idle_ff <= 1'b0;
      mrdata_ff <= 18'h00000;
      mr0_ff <= `FCS_MR_RESET;
      mr2_ff <= `FCS_MR_RESET;
    end
    else
    begin
      if (go_set)
      begin
        op_ff <= fcs_pkg::fcs_op_t'(wop);
        new_div_ff <= wdiv;
        odt_idle_ff <= wd[`FCS_CTRL_ODT];
      end
      if (wr_mrd)
        mrdata_ff <= wd[17:0];
      if (wr_mr0)
        mr0_ff <= wd[15:0];
      if (wr_mr2)
        mr2_ff <= wd[15:0];
    end
  end
  // Pending, error and done flags; a set wins over a clear.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      go_ff <= 1'b0;
      err_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      go_ff <= go_set || (go_ff && !take);
      err_ff <= err_set || (err_ff && !wr_ctrl);
      done_ff <= (take && state_ff != fcs_pkg::C_IDLE) ||
        (done_ff && !wr_ctrl);
    end
  end
  // ==========================================================
  // Memory clock generation
  // Period changes only on div_ld.
  wire wrap = (phase_ff == div_ff - 8'h01);
  wire fall_ev = wrap && ck_ff;
  wire rise_ev = wrap && !ck_ff;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_ff <= `FCS_DIV_RESET;
      phase_ff <= 8'h00;
      ck_ff <= 1'b0;
    end
    else if (div_ld)
    begin
      div_ff <= new_div_ff;
      phase_ff <= 8'h00;
    end
    else if (wrap)
    begin
      phase_ff <= 8'h00;
      ck_ff <= !ck_ff;
    end
    else
      phase_ff <= phase_ff + 8'h01;
  end
  function automatic logic [9:0] ru_nck(input int ns, input logic [7:0] dv);
    int per;
    int q;
    per = 2 * int'(dv) * `FCS_CORE_NS;
    q = (ns + per - 1) / per;
    if (q < 1)
      q = 1;
    return q[9:0];
  endfunction : ru_nck
  fcs_nck_cnt #(.W(10)) u_wait (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(ld),
    .load_val(ld_val),
    .tick(rise_ev),
    .done(cnt_done)
  );
  // Lock time from the DLL reset.
  // The guard edge keeps ODT low through the last relock edge.
  fcs_nck_cnt #(.W(10)) u_dllk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(dllk_ld),
    .load_val(`FCS_T_DLLK_NCK + `FCS_T_EDGE_GUARD),
    .tick(rise_ev),
    .done(dllk_done)
  );
  // ==========================================================
  // Sequencer
  wire is_sr = (op_ff == fcs_pkg::OP_SR);
  wire mrs_rtt = mrdata_ff[`FCS_RTT_BIT_A] | mrdata_ff[`FCS_RTT_BIT_B]
    | mrdata_ff[`FCS_RTT_BIT_C];
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cke = cke_ff;
    nxt_odt = odt_ff;
    nxt_cmd = fcs_pkg::CMD_NOP;
    nxt_sel = sel_ff;
    nxt_addr = addr_ff;
    take = 1'b0;
    ld = 1'b0;
    ld_val = `FCS_T_MRD_NCK;
    div_ld = 1'b0;
    dllk_ld = 1'b0;
    case (state_ff)
      fcs_pkg::C_IDLE:
      begin
        nxt_odt = odt_idle_ff;
        if (go_ff && fall_ev)
        begin
          take = 1'b1;
          if (op_ff == fcs_pkg::OP_MRS)
          begin
            nxt_cmd = fcs_pkg::CMD_MRS;
            nxt_sel = mrdata_ff[`FCS_MRSEL_MSB:`FCS_MRSEL_LSB];
            nxt_addr = mrdata_ff[15:0];
            ld = 1'b1;
            nxt_state = fcs_pkg::C_WAIT_MRD;
          end
          else if (op_ff != fcs_pkg::OP_NONE)
          begin
            nxt_cke = 1'b0;
            nxt_odt = (rtt_ff || !is_sr) ? 1'b0 : odt_idle_ff;
            nxt_cmd = is_sr ? fcs_pkg::CMD_SRE : fcs_pkg::CMD_NOP;
            ld = 1'b1;
            ld_val = ru_nck(`FCS_T_CKSRE_NS, div_ff);
            // The memory also counts tCKSRE in its own clock edges.
            if (ld_val < `FCS_T_CKSRE_NCK)
              ld_val = `FCS_T_CKSRE_NCK;
            nxt_state = fcs_pkg::C_WAIT_SRE;
          end
        end
      end
      fcs_pkg::C_WAIT_SRE:
        if (cnt_done && fall_ev)
          nxt_state = fcs_pkg::C_CHANGE;
      // Same path for either exit speed.
      fcs_pkg::C_CHANGE:
      begin
        div_ld = 1'b1;
        ld = 1'b1;
        // The stretched first half of the new clock is not counted.
        ld_val = ru_nck(`FCS_T_CKSRX_NS, new_div_ff) + `FCS_T_EDGE_GUARD;
        nxt_state = fcs_pkg::C_WAIT_SRX;
      end
      fcs_pkg::C_WAIT_SRX:
        if (cnt_done && fall_ev)
        begin
          nxt_cke = 1'b1;
          nxt_odt = 1'b0;
          ld = 1'b1;
          ld_val = is_sr ? ru_nck(`FCS_T_XS_NS, div_ff) :
            ru_nck(`FCS_T_XP_NS, div_ff);
          nxt_state = fcs_pkg::C_WAIT_XP;
        end
      fcs_pkg::C_WAIT_XP:
        if (cnt_done && fall_ev)
        begin
          nxt_cmd = fcs_pkg::CMD_MRS;
          nxt_sel = `FCS_MR0_SEL;
          nxt_addr = mr0_ff;
          nxt_addr[`FCS_DLL_RST_BIT] = 1'b1;
          dllk_ld = 1'b1;
          ld = 1'b1;
          nxt_state = fcs_pkg::C_WAIT_MR0;
        end
      fcs_pkg::C_WAIT_MR0:
        if (cnt_done && fall_ev)
        begin
          nxt_cmd = fcs_pkg::CMD_MRS;
          nxt_sel = `FCS_MR2_SEL;
          nxt_addr = mr2_ff;
          nxt_state = fcs_pkg::C_WAIT_DLLK;
        end
      // ODT low, CKE high while relocking.
      fcs_pkg::C_WAIT_DLLK:
        if (dllk_done && fall_ev)
        begin
          take = 1'b1;
          nxt_odt = odt_idle_ff;
          nxt_state = fcs_pkg::C_IDLE;
        end
      fcs_pkg::C_WAIT_MRD:
        if (cnt_done && fall_ev)
          nxt_state = fcs_pkg::C_IDLE;
      default:
        nxt_state = fcs_pkg::C_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= fcs_pkg::C_IDLE;
      cke_ff <= 1'b1;
      odt_ff <= 1'b0;
      sel_ff <= 2'h0;
      addr_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      cke_ff <= nxt_cke;
      odt_ff <= nxt_odt;
      sel_ff <= nxt_sel;
      addr_ff <= nxt_addr;
    end
  end
  // Command lasts one memory clock period.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cmd_ff <= fcs_pkg::CMD_NOP;
    else if (fall_ev || state_ff == fcs_pkg::C_CHANGE)
      cmd_ff <= nxt_cmd;
  end
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rtt_ff <= 1'b0;
    else if (take && op_ff == fcs_pkg::OP_MRS
      && mrdata_ff[`FCS_MRSEL_MSB:`FCS_MRSEL_LSB] == `FCS_MR1_SEL)
      rtt_ff <= mrs_rtt;
  end
  assign link.ck = ck_ff;
  assign link.cke = cke_ff;
  assign link.odt = odt_ff;
  assign link.cmd = cmd_ff;
  assign link.mr_sel = sel_ff;
  assign link.addr = addr_ff;
endmodule : fcs_ctrl

/* test/fcs_link_asserts.sv */
// Concurrent checks on the controller to memory link.
`timescale 1ns/1ps
`include "fcs_map.svh"
module fcs_link_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link
  input wire logic ck,
  input wire logic cke,
  input wire logic odt,
  input wire logic [1:0] cmd,
  input wire logic [1:0] mr_sel,
  input wire logic [15:0] addr
);
  // ==========================================================
  // Helper counters
  logic ck_d_ff, cke_d_ff, one_ff, xit_ff;
  logic [5:0] cnt_ff, half_ff;
  logic [2:0] mrd_ff;
  logic [9:0] dllk_ff;
  wire rise = ck & ~ck_d_ff;
  wire tgl = ck ^ ck_d_ff;
  wire mrs = rise && (cmd == fcs_pkg::CMD_MRS);
  wire dllr = mrs && xit_ff;
  wire [2:0] nxt_mrd = (mrd_ff == 3'h4) ? 3'h4 : mrd_ff + 3'h1;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {ck_d_ff, cke_d_ff, one_ff, xit_ff} <= 4'h4;
      {cnt_ff, half_ff} <= 12'h000;
      mrd_ff <= 3'h4;
      dllk_ff <= 10'h200;
    end
    else
    begin
      ck_d_ff <= ck;
      cke_d_ff <= cke;
      cnt_ff <= tgl ? 6'h01 : cnt_ff + 6'h01;
      if (tgl)
        one_ff <= 1'b1;
      if (tgl)
        half_ff <= one_ff ? cnt_ff : 6'h00;
      if (cke && !cke_d_ff)
        xit_ff <= 1'b1;
      else if (mrs)
        xit_ff <= 1'b0;
      if (rise)
        mrd_ff <= mrs ? 3'h1 : nxt_mrd;
      if (dllr)
        dllk_ff <= 10'h000;
      else if (rise && dllk_ff < 10'h200)
        dllk_ff <= dllk_ff + 10'h001;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_exit;
    $rose(cke);
  endsequence
  sequence s_dll_rst;
    !odt ##[1:300] mrs;
  endsequence
  a_clk_fixed: assert property (tgl && half_ff != 6'h00 &&
    cnt_ff != half_ff |-> !cke) else $error("ck period changed with cke high");
  a_cmd_on_fall: assert property ($changed(cmd) |-> $fell(ck))
    else $error("cmd changed away from ck fall");
  a_sre_cke_low: assert property (cmd == fcs_pkg::CMD_SRE |-> !cke)
    else $error("self-refresh entry with cke high");
  a_mrs_cke_high: assert property (cmd == fcs_pkg::CMD_MRS |-> cke)
    else $error("mode register set with cke low");
  a_mrs_spacing: assert property (mrs |-> mrd_ff == 3'h4)
    else $error("mode register sets closer than four edges");
  a_exit_dll_rst: assert property (s_exit |-> s_dll_rst)
    else $error("no DLL reset after exit");
  a_dll_rst_bit: assert property (dllr |-> mr_sel == `FCS_MR0_SEL &&
    addr[`FCS_DLL_RST_BIT]) else $error("DLL reset lacks bit eight");
  a_relock_hold: assert property (dllk_ff < 10'h200 |-> cke && !odt)
    else $error("cke or odt moved during relock");
endmodule : fcs_link_asserts

/* test/tb.sv */
// Self-checking bench for the frequency change sequencer.
`timescale 1ns/1ps
`include "fcs_map.svh"
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic dll_locked, clk_ignored, rtt_on;
  logic [1:0] bresp, rresp, mem_state, rsp;
  logic [31:0] rdata, rd;
  logic [3:0] seen = 4'h0;
  logic ign = 1'b0, lck_lo = 1'b0, rtt_bad = 1'b0;
  int error_cnt = 0;
  int n_tests = 0;
  fcs_link_if link ();
  fcs_ctrl u_fcs_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link.ctrl));
  fcs_mem u_fcs_mem (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link.mem), .dll_locked(dll_locked), .clk_ignored(clk_ignored),
    .rtt_on(rtt_on), .mem_state(mem_state));
  fcs_link_asserts u_fcs_link_asserts (.core_clk(core_clk),
    .sys_rst(sys_rst), .ck(link.ck), .cke(link.cke), .odt(link.odt),
    .cmd(link.cmd), .mr_sel(link.mr_sel), .addr(link.addr));
  always #20 core_clk = ~core_clk;
  // ==========================================================
  // Memory state monitor
  always @(posedge core_clk)
  begin
    seen[mem_state] <= 1'b1;
    if (clk_ignored === 1'b1)
      ign <= 1'b1;
    if (dll_locked === 1'b0 && !sys_rst)
      lck_lo <= 1'b1;
    if (rtt_on === 1'b1 && mem_state != 2'h0)
      rtt_bad <= 1'b1;
  end
  // ==========================================================
  // Bus tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic go(input logic [1:0] op, input logic [7:0] dv,
    input logic o);
    axi_wr(`FCS_ADDR_CTRL, {16'h0000, dv, 4'h0, o, op, 1'b1});
  endtask : go
  task automatic wait_idle;
    do
      axi_rd(`FCS_ADDR_STATUS);
    while (rd[0] !== 1'b0);
  endtask : wait_idle
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    #2000000;
    error_cnt++;
    give_verdict();
  end
  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    axi_rd(`FCS_ADDR_STATUS);
    chk("status_rst", rd & 32'h00FF007F, 32'h00020000);
    axi_wr(8'h20, 32'h1);
    chk("bresp_bad", {30'h0, rsp}, {30'h0, `FCS_RESP_SLVERR});
    axi_rd(8'h24);
    chk("rresp_bad", {30'h0, rsp}, {30'h0, `FCS_RESP_SLVERR});
    chk("rdata_bad", rd, 32'h0);
    axi_wr(`FCS_ADDR_MRDATA, 32'h00010004);
    go(2'h3, 8'h02, 1'b0);
    wait_idle();
    chk("term", rd & 32'h0000000F, 32'h00000008);
    axi_wr(`FCS_ADDR_MR0, 32'h00000520);
    axi_wr(`FCS_ADDR_MR2, 32'h00000018);
    go(2'h1, 8'h04, 1'b1);
    go(2'h1, 8'h04, 1'b1);
    axi_rd(`FCS_ADDR_STATUS);
    chk("busy_err", rd & 32'h3, 32'h3);
    wait_idle();
    chk("sr_done", rd & 32'h00FF0004, 32'h00040004);
    chk("ignored", {31'h0, ign}, 32'h1);
    chk("states", {28'h0, seen}, 32'hB);
    chk("relock", {30'h0, lck_lo, dll_locked}, 32'h3);
    for (int i = 0; i < 2; i++)
    begin
      go(2'h2, i ? 8'h11 : 8'h00, 1'b0);
      axi_rd(`FCS_ADDR_STATUS);
      chk("div_range", rd & 32'h00FF0003, 32'h00040002);
    end
    go(2'h2, `FCS_DIV_MIN, 1'b1);
    wait_idle();
    chk("pd_done", rd & 32'h00FF0004, 32'h00010004);
    chk("pd_seen", {31'h0, seen[2]}, 32'h1);
    chk("rtt_off", {31'h0, rtt_bad}, 32'h0);
    give_verdict();
  end
endmodule : tb
